// ### logic/tir_pkg.sv
// shared constants for the transparent inline repeater
package tir_pkg;

    // clock and serial bit timing
    localparam int CLK_NS    = 10;
    localparam int BIT_NS    = 4000;
    localparam int BIT_CYC   = BIT_NS / CLK_NS;
    localparam int HALF_CYC  = BIT_CYC / 2;
    localparam int STOP2_BIT = 10;            // index of the second stop bit in a slot

    // port count and data buffer shape
    localparam int N_DN   = 4;
    localparam int FIFO_W = 1;
    localparam int FIFO_D = 8;

    // turnaround and delay limits, in microseconds
    localparam int TURN_MAX_US  = 132;
    localparam int DELAY_MAX_US = 88;
    localparam int BRK_CUT_US   = 22;

    // discovery turnaround window: controller gap less margin
    localparam int DISC_GAP_US    = 5800;
    localparam int DISC_MARGIN_US = 200;
    localparam int DISC_CYC       = (DISC_GAP_US - DISC_MARGIN_US) * 1000 / CLK_NS;

    // a line held low longer than one slot time is a break
    localparam int SLOT_US = 44;
    localparam int BRK_CYC = SLOT_US * 1000 / CLK_NS;

    // longest receive inter-slot gap; a quiet reply line past it is over
    localparam int IDLE_US  = 2100;
    localparam int IDLE_CYC = IDLE_US * 1000 / CLK_NS;

    // slot positions inside a managed packet
    localparam logic [8:0] SLOT_START = 9'h000;
    localparam logic [8:0] SLOT_LEN   = 9'h002;
    localparam logic [8:0] SLOT_CLASS = 9'h014;

    // counter widths
    localparam int GAP_W  = 20;
    localparam int LOW_W  = 13;
    localparam int IDLE_W = 18;
    localparam int TICK_W = 9;

    typedef enum logic [1:0] {ST_FWD, ST_TURN, ST_REV} tir_state_e;
    typedef enum logic {DC_IDLE, DC_BITS} tir_dec_e;

endpackage

// ### logic/tir_fifo_if.sv
`timescale 1ns/1ns
// stream carrier between the repeater core and its sample buffer
interface tir_fifo_if #(parameter int W = 1);
    logic         flush;
    logic         wr_valid;
    logic         wr_ready;
    logic [W-1:0] wr_data;
    logic         rd_valid;
    logic         rd_ready;
    logic [W-1:0] rd_data;

    modport core (output flush, output wr_valid, input wr_ready, output wr_data,
                  input rd_valid, output rd_ready, input rd_data);
    modport fifo (input flush, input wr_valid, output wr_ready, input wr_data,
                  output rd_valid, input rd_ready, output rd_data);
endinterface

// ### logic/tir_fifo.sv
`timescale 1ns/1ns
// small synchronous fifo with flush; full still accepts while a read drains
module tir_fifo #(
    parameter int W = 1,
    parameter int D = 8
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    tir_fifo_if.fifo  f
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0]   cnt_r;

    wire full_w  = (cnt_r == (AW+1)'(D));
    wire empty_w = (cnt_r == '0);
    wire do_rd   = f.rd_ready && !empty_w;
    wire do_wr   = f.wr_valid && f.wr_ready;

    // a full buffer takes a word only when one leaves in the same cycle
    assign f.wr_ready = !full_w || f.rd_ready;
    assign f.rd_valid = !empty_w;
    assign f.rd_data  = mem[rp_r];

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == (AW)'(D - 1)) ? '0 : p + 1'b1;
    endfunction

    // storage has no reset, only the pointers and fill level do
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wp_r] <= f.wr_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else if (f.flush) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (do_wr) begin
                wp_r <= bump(wp_r);
            end
            if (do_rd) begin
                rp_r <= bump(rp_r);
            end
            cnt_r <= cnt_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule

// ### logic/tir_repeater.sv
`timescale 1ns/1ns
// Overview of operation
// - upstream port faces the controller; downstream ports face end devices.
// - never starts discovery itself; only relays between upstream and downstream.
// - after a relayed request ends, listen on downstream ports within 132 us.
// - after a request the first port to go low becomes active; later ones ignored.
// - if the upstream port wins, return to forward flow.
// - a winning downstream port drives upstream, and here the other downstream ports too.
// - after a response ends, return to forward flow within 132 us.
// - after discovery, never return forward before 5.8 ms minus 200 us.
// - after discovery, be back forward by 5.8 ms even without a response end.
// - relay delay in each direction at most 88 us.
// - bit distortion within 1.875 percent, not accumulating across a slot.
// - any regenerated slot timing must meet packet timing limits.
// - only the break after a request may shorten, by at most 22 us.
// - plain null code packets with 88 us breaks pass through correctly.
// - packet contents may steer timing; add little to packet spacing.
// - packet end is the end of the final slot's second stop bit.
module tir_repeater import tir_pkg::*; #(
    parameter int unsigned DISC_CYC_P = DISC_CYC,
    parameter int unsigned BRK_CYC_P  = BRK_CYC,
    parameter int unsigned IDLE_CYC_P = IDLE_CYC,
    parameter logic [7:0]  START_CODE = 8'hCC,
    parameter logic [7:0]  CLS_DISC   = 8'h10,
    parameter logic [7:0]  CLS_GET    = 8'h20,
    parameter logic [7:0]  CLS_SET    = 8'h30
) (
    input  wire logic            clk,
    input  wire logic            sys_rst,
    input  wire logic            up_rx,
    output wire logic            up_tx,
    output wire logic            up_oe_n,
    input  wire logic [N_DN-1:0] dn_rx,
    output wire logic [N_DN-1:0] dn_tx,
    output wire logic [N_DN-1:0] dn_oe_n,
    output wire logic            rev_active,
    output wire logic            disc_window,
    output wire logic            overrun
);
    localparam int PW = $clog2(N_DN);

    tir_state_e      state_r;
    tir_state_e      state_nxt;
    tir_dec_e        dst_r;
    logic            disc_r;
    logic            disc_nxt;
    logic [PW-1:0]   act_r;
    logic [PW-1:0]   act_nxt;
    logic [N_DN:0]   prev_r;
    logic            sel_prev_r;
    logic [LOW_W-1:0]  low_r;
    logic [TICK_W-1:0] tick_r;
    logic [3:0]      bit_r;
    logic [7:0]      shift_r;
    logic            byte_done_r;
    logic [8:0]      slot_r;
    logic            pkt_open_r;
    logic            rdm_r;
    logic [7:0]      len_r;
    logic [7:0]      class_r;
    logic [GAP_W-1:0]  gap_r;
    logic [IDLE_W-1:0] idle_r;
    logic            primed_r;
    logic [3:0]      fill_r;
    logic            rev_r;
    logic            up_tx_r;
    logic            up_oe_n_r;
    logic [N_DN-1:0] dn_tx_r;
    logic [N_DN-1:0] dn_oe_n_r;
    logic            overrun_r;

    tir_fifo_if #(.W(FIFO_W)) fq ();

    // lowest set bit wins, so downstream port 0 (bit 0) beats any higher port in a tie
    function automatic logic [PW-1:0] first_dn(input logic [N_DN-1:0] v);
        logic [PW-1:0] idx;
        idx = '0;
        for (int i = N_DN - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = PW'(i);
            end
        end
        return idx;
    endfunction

    // port decode: bit 0 is upstream, bits above are downstream
    wire [N_DN:0] rx_all   = {dn_rx, up_rx};
    wire [N_DN:0] fall_all = prev_r & ~rx_all;
    wire          up_fall  = fall_all[0];
    wire [N_DN-1:0] dn_fall = fall_all[N_DN:1];

    // the decoder and buffer watch whichever port currently leads
    wire sel_rx   = (state_r == ST_REV) ? dn_rx[act_r] : up_rx;
    wire sel_fall = sel_prev_r && !sel_rx;
    wire st_chg   = (state_nxt != state_r);
    wire relaying = (state_r != ST_TURN);

    // break sensing: a low longer than a slot restarts slot counting
    wire brk_pulse = !sel_rx && (low_r == LOW_W'(BRK_CYC_P - 1));

    // bit timing inside a slot
    wire at_half = (tick_r == TICK_W'(HALF_CYC - 1));
    wire at_end  = (tick_r == TICK_W'(BIT_CYC - 1));
    wire in_data = (bit_r >= 4'h1) && (bit_r <= 4'h8);
    wire in_stop = (bit_r >= 4'h9);
    wire frm_err = at_half && ((bit_r == 4'h0 && sel_rx) || (in_stop && !sel_rx));

    // packet end lands on the last slot's second stop bit
    wire last_slot = (slot_r == {1'b0, len_r} + 9'h001);
    wire eop_w     = byte_done_r && pkt_open_r && rdm_r && last_slot;
    wire is_disc   = (class_r == CLS_DISC);
    wire is_req    = is_disc || (class_r == CLS_GET) || (class_r == CLS_SET);

    // turnaround timing
    wire gap_done  = (gap_r >= GAP_W'(DISC_CYC_P - 1));
    wire idle_done = (idle_r >= IDLE_W'(IDLE_CYC_P - 1));

    // buffer controls; the output stays at mark until the buffer is primed
    wire out_take = fq.rd_valid && primed_r;
    wire out_lvl  = out_take ? fq.rd_data[0] : 1'b1;

    assign fq.flush    = st_chg;
    assign fq.wr_valid = relaying && !st_chg;
    assign fq.wr_data  = sel_rx;
    assign fq.rd_ready = primed_r;

    // fixed delay: eight buffered samples plus the output register, 90 ns
    tir_fifo #(
        .W (FIFO_W),
        .D (FIFO_D)
    ) u_fifo (
        .clk     (clk),
        .sys_rst (sys_rst),
        .f       (fq)
    );

    // direction control
    always_comb begin
        state_nxt = state_r;
        disc_nxt  = disc_r;
        act_nxt   = act_r;
        unique case (state_r)
            ST_FWD: begin
                // requests only relayed, never originated here
                if (eop_w && is_req) begin
                    state_nxt = ST_TURN;
                    disc_nxt  = is_disc;
                end
            end
            ST_TURN: begin
                if (disc_r && gap_done) begin
                    state_nxt = ST_FWD;
                end else if (up_fall && !disc_r) begin
                    // during discovery only the gap timer restores forward flow
                    state_nxt = ST_FWD;
                end else if (|dn_fall) begin
                    state_nxt = ST_REV;
                    act_nxt   = first_dn(dn_fall);
                end
            end
            ST_REV: begin
                // discovery replies may carry no end; only the gap timer ends them
                if (disc_r) begin
                    if (gap_done) begin
                        state_nxt = ST_FWD;
                    end
                end else if (eop_w || idle_done) begin
                    state_nxt = ST_FWD;
                end
            end
        endcase
    end

    // direction state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ST_FWD;
            rev_r   <= 1'b0;
            disc_r  <= 1'b0;
            act_r   <= '0;
        end else begin
            state_r <= state_nxt;
            rev_r   <= (state_nxt == ST_REV);
            disc_r  <= (state_nxt == ST_FWD) ? 1'b0 : disc_nxt;
            act_r   <= act_nxt;
        end
    end

    // previous levels for edge finding
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_r     <= '1;
            sel_prev_r <= 1'b1;
        end else begin
            prev_r     <= rx_all;
            sel_prev_r <= sel_rx;
        end
    end

    // low-time counter, saturating so a stuck line does not wrap
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_r <= '0;
        end else if (sel_rx) begin
            low_r <= '0;
        end else if (low_r != '1) begin
            low_r <= low_r + 1'b1;
        end
    end

    // slot receiver: start, eight data bits lsb first, two stop bits
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dst_r       <= DC_IDLE;
            tick_r      <= '0;
            bit_r       <= '0;
            shift_r     <= '0;
            byte_done_r <= 1'b0;
        end else begin
            byte_done_r <= 1'b0;
            if (st_chg || brk_pulse || (dst_r == DC_BITS && frm_err)) begin
                dst_r <= DC_IDLE;
            end else if (dst_r == DC_IDLE) begin
                if (sel_fall) begin
                    dst_r  <= DC_BITS;
                    tick_r <= '0;
                    bit_r  <= '0;
                end
            end else begin
                tick_r <= at_end ? '0 : tick_r + 1'b1;
                if (at_half && in_data) begin
                    shift_r <= {sel_rx, shift_r[7:1]};
                end
                if (at_end) begin
                    // back-to-back slots: the next start bit may fall right here
                    if (bit_r == 4'(STOP2_BIT)) begin
                        dst_r       <= sel_fall ? DC_BITS : DC_IDLE;
                        bit_r       <= '0;
                        byte_done_r <= 1'b1;
                    end else begin
                        bit_r <= bit_r + 1'b1;
                    end
                end
            end
        end
    end

    // slot tracking: start code, length and command class steer turnaround
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            slot_r     <= '0;
            pkt_open_r <= 1'b0;
            rdm_r      <= 1'b0;
            len_r      <= '0;
            class_r    <= '0;
        end else if (brk_pulse || st_chg) begin
            slot_r     <= '0;
            pkt_open_r <= brk_pulse;
            rdm_r      <= 1'b0;
            class_r    <= '0;
        end else if (byte_done_r && pkt_open_r) begin
            slot_r <= slot_r + 1'b1;
            if (slot_r == SLOT_START) begin
                rdm_r <= (shift_r == START_CODE);
            end
            if (slot_r == SLOT_LEN) begin
                len_r <= shift_r;
            end
            if (slot_r == SLOT_CLASS) begin
                class_r <= shift_r;
            end
            if (eop_w) begin
                pkt_open_r <= 1'b0;
            end
        end
    end

    // discovery gap counts from the request end; quiet-line guard for replies
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gap_r  <= '0;
            idle_r <= '0;
        end else begin
            if (state_r == ST_FWD) begin
                gap_r <= '0;
            end else if (!gap_done) begin
                gap_r <= gap_r + 1'b1;
            end
            if (state_r != ST_REV || !sel_rx) begin
                idle_r <= '0;
            end else if (!idle_done) begin
                idle_r <= idle_r + 1'b1;
            end
        end
    end

    // priming: reading starts as the ninth sample goes in, so no sample is
    // ever refused and the lag stays the same for every edge
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fill_r    <= '0;
            primed_r  <= 1'b0;
            overrun_r <= 1'b0;
        end else begin
            if (st_chg) begin
                fill_r   <= '0;
                primed_r <= 1'b0;
            end else if (fq.wr_valid && !primed_r) begin
                fill_r   <= fill_r + 1'b1;
                primed_r <= (fill_r == 4'(FIFO_D - 1));
            end
            if (fq.wr_valid && !fq.wr_ready) begin
                overrun_r <= 1'b1;
            end
        end
    end

    // edges pass through unchanged, so break length is kept but for a
    // few cycles lost at the turn, far below the allowed shortening
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            up_tx_r   <= 1'b1;
            up_oe_n_r <= 1'b1;
            dn_tx_r   <= '1;
            dn_oe_n_r <= '0;
        end else begin
            up_tx_r   <= (state_nxt == ST_REV) ? out_lvl : 1'b1;
            up_oe_n_r <= (state_nxt != ST_REV);
            for (int i = 0; i < N_DN; i++) begin
                if (state_r == ST_FWD) begin
                    dn_tx_r[i] <= out_lvl;
                end else if (state_r == ST_REV && act_r != PW'(i)) begin
                    dn_tx_r[i] <= out_lvl;
                end else begin
                    dn_tx_r[i] <= 1'b1;
                end
                dn_oe_n_r[i] <= !((state_nxt == ST_FWD)
                               || (state_nxt == ST_REV && act_nxt != PW'(i)));
            end
        end
    end

    assign up_tx       = up_tx_r;
    assign up_oe_n     = up_oe_n_r;
    assign dn_tx       = dn_tx_r;
    assign dn_oe_n     = dn_oe_n_r;
    assign rev_active  = rev_r;
    assign disc_window = disc_r;
    assign overrun     = overrun_r;
endmodule

// ### test/tir_repeater_asserts.sv
`timescale 1ns/1ns
// pin-level watcher of the repeater: direction switching and timing bounds
module tir_repeater_asserts import tir_pkg::*; #(
    parameter int unsigned DISC_CYC_P = DISC_CYC,
    parameter int unsigned IDLE_CYC_P = IDLE_CYC
) (
    input wire logic            clk,
    input wire logic            sys_rst,
    input wire logic            up_rx,
    input wire logic            up_tx,
    input wire logic            up_oe_n,
    input wire logic [N_DN-1:0] dn_rx,
    input wire logic [N_DN-1:0] dn_tx,
    input wire logic [N_DN-1:0] dn_oe_n,
    input wire logic            rev_active,
    input wire logic            disc_window,
    input wire logic            overrun
);
    logic [3:0]  fwd_cnt_r;
    logic [31:0] disc_cnt_r;
    logic [31:0] quiet_cnt_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // settle count after entering forward (buffer primes first), window age, quiet reply line
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fwd_cnt_r   <= '0;
            disc_cnt_r  <= '0;
            quiet_cnt_r <= '0;
        end else begin
            fwd_cnt_r   <= (dn_oe_n != '0) ? 4'h0 : fwd_cnt_r + 4'(fwd_cnt_r != 4'hF);
            disc_cnt_r  <= disc_window ? disc_cnt_r + 32'h0000_0001 : '0;
            quiet_cnt_r <= (rev_active && (&dn_rx)) ? quiet_cnt_r + 32'h0000_0001 : '0;
        end
    end

    // eight buffered samples plus the output register: nine stages
    a_fwd_relay_delay: assert property (fwd_cnt_r == 4'hF |->
        dn_tx == {N_DN{$past(up_rx, 9)}}) else $error("forward relay lost or distorted");
    a_up_quiet_fwd: assert property (dn_oe_n == '0 |-> up_oe_n && up_tx)
        else $error("upstream driven during forward flow");
    a_rev_drive_up: assert property ($rose(rev_active) |-> ##[0:1] !up_oe_n)
        else $error("reply not driven upstream");
    a_rev_one_port: assert property (rev_active |-> $onehot(dn_oe_n))
        else $error("not exactly one listening port in reverse");
    a_rev_port_held: assert property (rev_active && $past(rev_active) |-> $stable(dn_oe_n))
        else $error("active port changed in reverse");
    a_turn_silent: assert property ((&dn_oe_n) |-> (&dn_tx) && up_oe_n)
        else $error("traffic started while listening");
    a_up_wins_fwd: assert property ((&dn_oe_n) && up_oe_n && !disc_window && !up_rx
        |-> ##[1:2] dn_oe_n == '0) else $error("upstream break did not restore forward");
    a_rev_quiet_exit: assert property (rev_active && !disc_window |->
        quiet_cnt_r <= IDLE_CYC_P + 1) else $error("reverse held past quiet limit");
    a_disc_no_early: assert property ($fell(disc_window) |-> disc_cnt_r >= DISC_CYC_P - 3)
        else $error("discovery window closed early");
    a_disc_no_late: assert property (disc_window |-> disc_cnt_r <= DISC_CYC_P + 2)
        else $error("discovery window overran");
    a_disc_no_fwd: assert property (disc_window && $past(disc_window) |-> dn_oe_n != '0)
        else $error("forward flow inside discovery window");
    a_no_overrun: assert property (!overrun)
        else $error("sample buffer refused data");
endmodule

bind tir_repeater tir_repeater_asserts #(
    .DISC_CYC_P(DISC_CYC_P),
    .IDLE_CYC_P(IDLE_CYC_P)
) i_tir_repeater_asserts (.clk(clk), .sys_rst(sys_rst), .up_rx(up_rx), .up_tx(up_tx),
    .up_oe_n(up_oe_n), .dn_rx(dn_rx), .dn_tx(dn_tx), .dn_oe_n(dn_oe_n),
    .rev_active(rev_active), .disc_window(disc_window), .overrun(overrun));

// ### test/tir_partner.sv
`timescale 1ns/1ns
// controller on line 0, responders on lines 1..N_DN; en low means released
module tir_partner import tir_pkg::*; (
    input  wire logic     clk,
    output logic [N_DN:0] lvl,
    output logic [N_DN:0] en
);
    // a released line is pulled to mark by the bias network
    initial begin
        lvl = '1;
        en  = '0;
    end

    // one level for n cycles, changed just after a falling edge
    task automatic hold(input int p, input logic v, input int n);
        lvl[p] = v;
        repeat (n) @(negedge clk);
    endtask

    // optional 88 us break and mark-after-break, then 8N2 slots back to back
    task automatic send(input int p, input bit brk, input logic [7:0] d[$]);
        en[p] = 1'b1;
        if (brk) begin
            hold(p, 1'b0, 8800);
            hold(p, 1'b1, 800);
        end
        foreach (d[k]) begin
            hold(p, 1'b0, BIT_CYC);
            for (int b = 0; b < 8; b++) begin
                hold(p, d[k][b], BIT_CYC);
            end
            hold(p, 1'b1, 2 * BIT_CYC);
        end
        en[p] = 1'b0;
    endtask

    // stray low pulse, used as a late arrival on a port
    task automatic pulse(input int p, input int n);
        en[p] = 1'b1;
        hold(p, 1'b0, n);
        lvl[p] = 1'b1;
        en[p]  = 1'b0;
    endtask
endmodule

// ### test/tb.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_fail++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
// self-checking bench; long counts scaled down through parameters
module tb import tir_pkg::*;;
    localparam int DISC_T = 20000;
    localparam int IDLE_T = 20000;
    localparam int TURN_T = TURN_MAX_US * 100;
    localparam int CUT_T  = BRK_CUT_US * 100;

    logic                clk = 1'b0;
    logic                sys_rst = 1'b1;
    wire logic           up_rx;
    wire logic [N_DN-1:0] dn_rx;
    logic                up_tx;
    logic                up_oe_n;
    logic [N_DN-1:0]     dn_tx;
    logic [N_DN-1:0]     dn_oe_n;
    logic                rev_active;
    logic                disc_window;
    logic                overrun;
    logic [N_DN:0]       pl;
    logic [N_DN:0]       pe;
    logic                mon_on = 1'b0;
    logic                mon_sel = 1'b0;
    int                  lo_b;
    int                  n_fail = 0;
    int                  cmp_count = 0;
    int unsigned         seed = 76;
    logic [7:0]          pkt[$];

    always #5 clk = ~clk;

    // wire levels: a partner that drives wins, else the repeater, else bias mark
    assign up_rx = pe[0] ? pl[0] : (up_tx | up_oe_n);
    assign dn_rx = (pe[N_DN:1] & pl[N_DN:1]) | (~pe[N_DN:1] & (dn_tx | dn_oe_n));

    tir_repeater #(.DISC_CYC_P(DISC_T), .IDLE_CYC_P(IDLE_T)) i_tir_repeater (.clk(clk),
        .sys_rst(sys_rst), .up_rx(up_rx), .up_tx(up_tx), .up_oe_n(up_oe_n), .dn_rx(dn_rx),
        .dn_tx(dn_tx), .dn_oe_n(dn_oe_n), .rev_active(rev_active),
        .disc_window(disc_window), .overrun(overrun));
    tir_partner i_tir_partner (.clk(clk), .lvl(pl), .en(pe));

    // low cycles seen on the relayed output
    always @(negedge clk) begin
        if (mon_on) begin
            lo_b += int'(!(mon_sel ? up_tx : dn_tx[0]));
        end
    end

    function logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // low time of a frame: break plus start bit and zero data bits of every slot
    function automatic int lo_exp(input bit brk, input logic [7:0] d[$]);
        int n = brk ? 8800 : 0;
        foreach (d[k]) n += BIT_CYC * (9 - $countones(d[k]));
        return n;
    endfunction

    // in reverse only the active port listens
    function automatic logic [N_DN-1:0] rev_oe(input int i);
        return N_DN'(1) << i;
    endfunction

    function logic probe(input int w);
        case (w)
            0: return &dn_oe_n;
            1: return rev_active;
            2: return dn_oe_n == '0;
            default: return disc_window;
        endcase
    endfunction

    task wait_for(input int w, input logic v, input int lim, output int t);
        for (t = 0; t < lim && probe(w) !== v; t++) begin
            @(negedge clk);
        end
    endtask

    // managed request with length 20, class in slot 20, random filler
    task mk_req(input logic [7:0] cls);
        pkt.delete();
        for (int s = 0; s < 22; s++) begin
            pkt.push_back(s == 0 ? 8'hCC : s == 2 ? 8'h14 : s == 20 ? cls : rnd());
        end
    endtask

    task end_of_test();
        $display("counts cmp_count=%0d n_fail=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        int  t;
        time t0;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        `CHK("up_oe_n", 1'b1, up_oe_n)
        `CHK("up_tx", 1'b1, up_tx)
        `CHK("dn_oe_n", {N_DN{1'b0}}, dn_oe_n)
        `CHK("dn_tx", {N_DN{1'b1}}, dn_tx)
        `CHK("flags", 3'h0, {rev_active, disc_window, overrun})
        $display("test reset done");
        // null code packet, then a random non-managed start code
        for (int k = 0; k < 2; k++) begin
            pkt = '{(k == 0) ? 8'h00 : (rnd() & 8'h7F), rnd(), rnd()};
            lo_b = 0;
            mon_on = 1'b1;
            i_tir_partner.send(0, 1'b1, pkt);
            repeat (20) @(negedge clk);
            mon_on = 1'b0;
            `CHK("fwd_low", lo_exp(1'b1, pkt), lo_b)
        end
        $display("test forward done");
        // request, reply on port 2 with a late stray edge on port 0
        mk_req(8'h20);
        i_tir_partner.send(0, 1'b1, pkt);
        wait_for(0, 1'b1, TURN_T, t);
        `CHK("turn_time", 1'b1, t < TURN_T)
        `CHK("turn_dn_tx", {N_DN{1'b1}}, dn_tx)
        repeat (300) @(negedge clk);
        pkt = '{8'hCC, 8'h01, 8'h03, 8'h55, 8'hAA};
        mon_sel = 1'b1;
        lo_b = 0;
        mon_on = 1'b1;
        fork
            i_tir_partner.send(3, 1'b1, pkt);
            begin
                wait_for(1, 1'b1, 40, t);
                `CHK("rev_port", rev_oe(2), dn_oe_n)
                `CHK("rev_up_oe_n", 1'b0, up_oe_n)
                i_tir_partner.pulse(1, 400);
                `CHK("rev_held", rev_oe(2), dn_oe_n)
            end
        join
        wait_for(1, 1'b0, TURN_T, t);
        mon_on = 1'b0;
        `CHK("resp_turn", 1'b1, t < TURN_T)
        `CHK("resp_fwd", {N_DN{1'b0}}, dn_oe_n)
        `CHK("rev_low", 1'b1, lo_b <= lo_exp(1, pkt) && lo_b + CUT_T >= lo_exp(1, pkt))
        $display("test request done");
        repeat (2000) @(negedge clk);
        // set request; the controller speaks first and takes the line back
        mk_req(8'h30);
        i_tir_partner.send(0, 1'b1, pkt);
        wait_for(0, 1'b1, TURN_T, t);
        `CHK("set_turn", 1'b1, t < TURN_T)
        repeat (300) @(negedge clk);
        pkt = '{8'h00, rnd()};
        fork
            i_tir_partner.send(0, 1'b1, pkt);
            begin
                wait_for(2, 1'b1, 40, t);
                `CHK("up_wins_oe", {N_DN{1'b0}}, dn_oe_n)
                `CHK("up_wins_flags", 2'h0, {rev_active, disc_window})
            end
        join
        $display("test upstream done");
        repeat (2000) @(negedge clk);
        // discovery; the breakless reply ends long before the window closes
        mk_req(8'h10);
        i_tir_partner.send(0, 1'b1, pkt);
        t0 = $time;
        wait_for(3, 1'b1, TURN_T, t);
        `CHK("disc_window", 1'b1, disc_window)
        repeat (300) @(negedge clk);
        pkt = '{8'hFE, 8'hFE, 8'hAA};
        fork
            i_tir_partner.send(2, 1'b0, pkt);
            begin
                wait_for(1, 1'b1, 40, t);
                `CHK("disc_rev_port", rev_oe(1), dn_oe_n)
            end
        join
        `CHK("disc_hold", 1'b1, dn_oe_n != '0)
        wait_for(2, 1'b1, DISC_T, t);
        t = int'(($time - t0) / CLK_NS);
        `CHK("disc_exit_early", 1'b1, t >= DISC_T - 4)
        `CHK("disc_exit_late", 1'b1, t <= DISC_T + 4)
        $display("test discovery done");
        end_of_test();
    end

    // about 440k cycles of traffic; the limit leaves margin
    initial begin
        repeat (500000) @(posedge clk);
        n_fail++;
        $display("ERROR watchdog expected finish seen timeout");
        end_of_test();
    end
endmodule
